// ===== tmio_pkg.sv
// Purpose: constants for the channel 1/2 general register pin function block
// Assumes: 40 MHz mclk_i, plain register port with read data one cycle after the read strobe
// Notes: register offsets are indices on the plain port
// How it works
// - upper nibble picks B, lower picks A
// - codes 0000/0100 disable pin; reset 0000
// - top bit clear: compare; bit2 initial level
// - compare low bits 01 drive pin low
// - compare low bits 10 drive pin high
// - compare low bits 11 toggle pin
// - code 1000 captures on pin rising edge
// - code 1001 captures on pin falling edge
// - codes 101x capture on both pin edges
// - ch1 upper 11xx captures on ch0 reg C event
// - ch1 lower 11xx captures on ch0 reg A event
// - ch2 upper 11xx mirrors 10xx edge captures
// - ch2 lower 11xx mirrors 10xx edge captures
package tmio_pkg;
   localparam logic [2:0] TMIO_OFS_CH1_IO = 3'h0;
   localparam logic [2:0] TMIO_OFS_CH2_IO = 3'h1;
   localparam logic [2:0] TMIO_OFS_CH1_GRA = 3'h2;
   localparam logic [2:0] TMIO_OFS_CH1_GRB = 3'h3;
   localparam logic [2:0] TMIO_OFS_CH2_GRA = 3'h4;
   localparam logic [2:0] TMIO_OFS_CH2_GRB = 3'h5;
   localparam logic [7:0] TMIO_IO_RESET = 8'h00;
   localparam logic [15:0] TMIO_GR_RESET = 16'hFFFF;
   localparam int TMIO_FLD_B_LSB = 4;
   localparam int TMIO_FLD_A_LSB = 0;
   localparam int TMIO_BIT_CAPTURE = 3;
   localparam int TMIO_BIT_INIT = 2;
   localparam logic [1:0] TMIO_OC_NONE = 2'h0;
   localparam logic [1:0] TMIO_OC_LOW = 2'h1;
   localparam logic [1:0] TMIO_OC_HIGH = 2'h2;
   localparam logic [1:0] TMIO_OC_TOGGLE = 2'h3;
endpackage

// ===== tmio_unit.sv
// Purpose: one general register with its pin function field
// Assumes: pin_i already synchronised; cnt_i on mclk_i
// Notes: chain_cap_i selects the other-channel source for codes 11xx
`timescale 1ns/100ps
`default_nettype none
module tmio_unit (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] fld_i,
   input wire logic fld_wr_i,
   input wire logic chain_cap_i,
   input wire logic chain_evt_i,
   input wire logic pin_i,
   input wire logic [15:0] cnt_i,
   input wire logic gr_wr_i,
   input wire logic [15:0] gr_wdata_i,
   output logic [15:0] gr_o,
   output logic pin_o,
   output logic pin_oe_n_o,
   output logic event_o
);
   typedef struct packed {
      logic pin_d;
      logic pin_lvl;
      logic oe_n;
      logic evt;
      logic [15:0] gr;
   } tmio_unit_type;
   tmio_unit_type st_reg, st_next;
   logic rise, fall, cap_hit, match;
   always_comb begin
      st_next = st_reg;
      rise = pin_i & ~st_reg.pin_d;
      fall = ~pin_i & st_reg.pin_d;
      match = (cnt_i == st_reg.gr);
      cap_hit = 1'b0;
      st_next.pin_d = pin_i;
      st_next.evt = 1'b0;
      if (fld_i[tmio_pkg::TMIO_BIT_CAPTURE]) begin
         st_next.oe_n = 1'b1;
         if (chain_cap_i && fld_i[2]) begin
            cap_hit = chain_evt_i;
         end else if (fld_i[1]) begin
            cap_hit = rise | fall;
         end else if (fld_i[0]) begin
            cap_hit = fall;
         end else begin
            cap_hit = rise;
         end
         if (cap_hit) begin
            st_next.gr = cnt_i;
            st_next.evt = 1'b1;
         end
      end else begin
         st_next.oe_n = (fld_i[1:0] == tmio_pkg::TMIO_OC_NONE);
         if (fld_wr_i) begin
            st_next.pin_lvl = fld_i[tmio_pkg::TMIO_BIT_INIT];
         end else if (match) begin
            st_next.evt = 1'b1;
            unique case (fld_i[1:0])
               tmio_pkg::TMIO_OC_NONE: st_next.pin_lvl = st_reg.pin_lvl;
               tmio_pkg::TMIO_OC_LOW: st_next.pin_lvl = 1'b0;
               tmio_pkg::TMIO_OC_HIGH: st_next.pin_lvl = 1'b1;
               tmio_pkg::TMIO_OC_TOGGLE: st_next.pin_lvl = ~st_reg.pin_lvl;
            endcase
         end
      end
      // a software write wins over a capture in the same cycle
      if (gr_wr_i) begin
         st_next.gr = gr_wdata_i;
      end
   end
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // idle pins sit at the pull-up level; a 1 here avoids a false rising edge after reset
         st_reg <= '{pin_d: 1'b1, pin_lvl: 1'b0, oe_n: 1'b1, evt: 1'b0, gr: tmio_pkg::TMIO_GR_RESET};
      end else begin
         st_reg <= st_next;
      end
   end
   assign gr_o = st_reg.gr;
   assign pin_o = st_reg.pin_lvl;
   assign pin_oe_n_o = st_reg.oe_n;
   assign event_o = st_reg.evt;

   capture_rise_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (fld_i == 4'h8 && !fld_wr_i && rise && !gr_wr_i) |=> (st_reg.gr == $past(cnt_i)))
      else $error("rising edge capture did not load the counter");
   capture_fall_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (fld_i == 4'h9 && rise && !gr_wr_i && $stable(st_reg.gr)) |=> (st_reg.gr == $past(st_reg.gr)))
      else $error("falling edge mode captured on a rising edge");
   out_disable_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (fld_i[3] == 1'b0 && fld_i[1:0] == 2'h0) |=> pin_oe_n_o)
      else $error("pin driven while output disabled");
   match_low_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (fld_i[3] == 1'b0 && fld_i[1:0] == 2'h1 && match && !fld_wr_i) |=> !pin_o)
      else $error("compare match did not drive pin low");
   match_high_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (fld_i[3] == 1'b0 && fld_i[1:0] == 2'h2 && match && !fld_wr_i) |=> pin_o)
      else $error("compare match did not drive pin high");
   match_toggle_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (fld_i[3] == 1'b0 && fld_i[1:0] == 2'h3 && match && !fld_wr_i) |=> (pin_o != $past(pin_o)))
      else $error("compare match did not toggle pin");
   init_level_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (fld_wr_i && !fld_i[3]) |=> (pin_o == $past(fld_i[2])))
      else $error("initial pin level not taken from field");
endmodule
`default_nettype wire

// ===== tmio_top.sv
// Purpose: pin function control for the two general registers of channels 1 and 2
// Assumes: counters and channel 0 events come from the enclosing timer on mclk_i
// Notes: pins are two-way; oe_n low means this block drives the pin
`timescale 1ns/100ps
`default_nettype none
module tmio_top (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [2:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic [15:0] ch1_cnt_i,
   input wire logic [15:0] ch2_cnt_i,
   input wire logic ch0_reg_a_evt_i,
   input wire logic ch0_reg_c_evt_i,
   input wire logic ch1_pin_a_i,
   input wire logic ch1_pin_b_i,
   input wire logic ch2_pin_a_i,
   input wire logic ch2_pin_b_i,
   output logic ch1_pin_a_o,
   output logic ch1_pin_b_o,
   output logic ch2_pin_a_o,
   output logic ch2_pin_b_o,
   output logic ch1_pin_a_oe_n_o,
   output logic ch1_pin_b_oe_n_o,
   output logic ch2_pin_a_oe_n_o,
   output logic ch2_pin_b_oe_n_o,
   output logic [3:0] capture_evt_o
);
   typedef struct packed {
      logic [7:0] io1;
      logic [7:0] io2;
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic [3:0] pin_prev;
      logic [15:0] rdata;
   } tmio_top_type;
   tmio_top_type st_reg, st_next;
   logic [15:0] gr [4];
   logic [3:0] pin_lvl, oe_n, evt;
   logic [3:0] fld [4];
   logic [3:0] fld_wr;
   logic [3:0] gr_wr;
   logic [3:0] chain_cap;
   logic [3:0] chain_evt;
   logic [15:0] cnt [4];
   logic [3:0] pin_rise;
   logic [3:0] pin_fall;
   // one decoder for every write strobe keeps the register map in one place
   function automatic logic wr_hit(input logic wr, input logic [2:0] addr, input logic [2:0] ofs);
      return wr && (addr == ofs);
   endfunction
   always_comb begin
      st_next = st_reg;
      // pins pass two flip-flops before any logic looks at them
      st_next.sync1 = {ch2_pin_b_i, ch2_pin_a_i, ch1_pin_b_i, ch1_pin_a_i};
      st_next.sync2 = st_reg.sync1;
      st_next.pin_prev = st_reg.sync2;
      st_next.rdata = 16'h0000;
      if (wr_hit(wr_i, addr_i, tmio_pkg::TMIO_OFS_CH1_IO)) begin
         st_next.io1 = wdata_i[7:0];
      end
      if (wr_hit(wr_i, addr_i, tmio_pkg::TMIO_OFS_CH2_IO)) begin
         st_next.io2 = wdata_i[7:0];
      end
      if (rd_i) begin
         unique case (addr_i)
            tmio_pkg::TMIO_OFS_CH1_IO: st_next.rdata = {8'h00, st_reg.io1};
            tmio_pkg::TMIO_OFS_CH2_IO: st_next.rdata = {8'h00, st_reg.io2};
            tmio_pkg::TMIO_OFS_CH1_GRA: st_next.rdata = gr[0];
            tmio_pkg::TMIO_OFS_CH1_GRB: st_next.rdata = gr[1];
            tmio_pkg::TMIO_OFS_CH2_GRA: st_next.rdata = gr[2];
            tmio_pkg::TMIO_OFS_CH2_GRB: st_next.rdata = gr[3];
            default: st_next.rdata = 16'h0000;
         endcase
      end
   end
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg <= '{io1: tmio_pkg::TMIO_IO_RESET, io2: tmio_pkg::TMIO_IO_RESET,
                     sync1: 4'hF, sync2: 4'hF, pin_prev: 4'hF, rdata: 16'h0000};
      end else begin
         st_reg <= st_next;
      end
   end
   // unit order: ch1 A, ch1 B, ch2 A, ch2 B
   always_comb begin
      // units see the field being written, so the initial level comes from the new code
      fld[0] = st_next.io1[tmio_pkg::TMIO_FLD_A_LSB +: 4];
      fld[1] = st_next.io1[tmio_pkg::TMIO_FLD_B_LSB +: 4];
      fld[2] = st_next.io2[tmio_pkg::TMIO_FLD_A_LSB +: 4];
      fld[3] = st_next.io2[tmio_pkg::TMIO_FLD_B_LSB +: 4];
      fld_wr[0] = wr_hit(wr_i, addr_i, tmio_pkg::TMIO_OFS_CH1_IO);
      fld_wr[1] = fld_wr[0];
      fld_wr[2] = wr_hit(wr_i, addr_i, tmio_pkg::TMIO_OFS_CH2_IO);
      fld_wr[3] = fld_wr[2];
      gr_wr[0] = wr_hit(wr_i, addr_i, tmio_pkg::TMIO_OFS_CH1_GRA);
      gr_wr[1] = wr_hit(wr_i, addr_i, tmio_pkg::TMIO_OFS_CH1_GRB);
      gr_wr[2] = wr_hit(wr_i, addr_i, tmio_pkg::TMIO_OFS_CH2_GRA);
      gr_wr[3] = wr_hit(wr_i, addr_i, tmio_pkg::TMIO_OFS_CH2_GRB);
      // channel 2 has no chained source, so 11xx falls back to pin edges
      chain_cap = 4'b0011;
      chain_evt = {2'b00, ch0_reg_c_evt_i, ch0_reg_a_evt_i};
      cnt[0] = ch1_cnt_i;
      cnt[1] = ch1_cnt_i;
      cnt[2] = ch2_cnt_i;
      cnt[3] = ch2_cnt_i;
   end
   for (genvar i = 0; i < 4; i++) begin : g_unit
      tmio_unit u_unit (
         .mclk_i(mclk_i),
         .rst_n_i(rst_n_i),
         .fld_i(fld[i]),
         .fld_wr_i(fld_wr[i]),
         .chain_cap_i(chain_cap[i]),
         .chain_evt_i(chain_evt[i]),
         .pin_i(st_reg.sync2[i]),
         .cnt_i(cnt[i]),
         .gr_wr_i(gr_wr[i]),
         .gr_wdata_i(wdata_i),
         .gr_o(gr[i]),
         .pin_o(pin_lvl[i]),
         .pin_oe_n_o(oe_n[i]),
         .event_o(evt[i])
      );
   end
   assign rdata_o = st_reg.rdata;
   assign ch1_pin_a_o = pin_lvl[0];
   assign ch1_pin_b_o = pin_lvl[1];
   assign ch2_pin_a_o = pin_lvl[2];
   assign ch2_pin_b_o = pin_lvl[3];
   assign ch1_pin_a_oe_n_o = oe_n[0];
   assign ch1_pin_b_oe_n_o = oe_n[1];
   assign ch2_pin_a_oe_n_o = oe_n[2];
   assign ch2_pin_b_oe_n_o = oe_n[3];
   assign capture_evt_o = evt;
   // same edge view as the units, for the checks below
   assign pin_rise = st_reg.sync2 & ~st_reg.pin_prev;
   assign pin_fall = ~st_reg.sync2 & st_reg.pin_prev;

   // register port
   field_reset_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      $rose(rst_n_i)
      |-> (st_reg.io1 == tmio_pkg::TMIO_IO_RESET))
      else $error("ch1 io control not cleared by reset");

   field_reset2_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      $rose(rst_n_i)
      |-> (st_reg.io2 == tmio_pkg::TMIO_IO_RESET))
      else $error("ch2 io control not cleared by reset");

   write_io1_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (wr_i && addr_i == tmio_pkg::TMIO_OFS_CH1_IO)
      |=> (st_reg.io1 == $past(wdata_i[7:0])))
      else $error("ch1 io control write lost");

   write_io2_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (wr_i && addr_i == tmio_pkg::TMIO_OFS_CH2_IO)
      |=> (st_reg.io2 == $past(wdata_i[7:0])))
      else $error("ch2 io control write lost");

   read_io1_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (rd_i && addr_i == tmio_pkg::TMIO_OFS_CH1_IO)
      |=> (rdata_o == {8'h00, $past(st_reg.io1)}))
      else $error("ch1 io control read wrong");

   read_io2_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (rd_i && addr_i == tmio_pkg::TMIO_OFS_CH2_IO)
      |=> (rdata_o == {8'h00, $past(st_reg.io2)}))
      else $error("ch2 io control read wrong");

   read_gr_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (rd_i && addr_i == tmio_pkg::TMIO_OFS_CH1_GRA)
      |=> (rdata_o == $past(gr[0])))
      else $error("ch1 register A read wrong");

   read_grb_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (rd_i && addr_i == tmio_pkg::TMIO_OFS_CH2_GRB)
      |=> (rdata_o == $past(gr[3])))
      else $error("ch2 register B read wrong");

   read_idle_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      !rd_i
      |=> (rdata_o == 16'h0000))
      else $error("read data not zero outside a read");

   unmapped_read_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (rd_i && addr_i > tmio_pkg::TMIO_OFS_CH2_GRB)
      |=> (rdata_o == 16'h0000))
      else $error("unmapped index did not read zero");

   // channel 0 chaining
   chain_c_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (st_reg.io1[7:6] == 2'h3 && ch0_reg_c_evt_i && !gr_wr[1] && !fld_wr[1])
      |=> (gr[1] == $past(ch1_cnt_i)))
      else $error("ch1 register B missed channel 0 event");

   chain_a_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (st_reg.io1[3:2] == 2'h3 && ch0_reg_a_evt_i && !gr_wr[0] && !fld_wr[0])
      |=> (gr[0] == $past(ch1_cnt_i)))
      else $error("ch1 register A missed channel 0 event");

   chain_c_idle_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (st_reg.io1[7:6] == 2'h3 && !ch0_reg_c_evt_i && !gr_wr[1] && !fld_wr[1])
      |=> $stable(gr[1]))
      else $error("ch1 register B captured with no channel 0 event");

   chain_a_idle_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (st_reg.io1[3:2] == 2'h3 && !ch0_reg_a_evt_i && !gr_wr[0] && !fld_wr[0])
      |=> $stable(gr[0]))
      else $error("ch1 register A captured with no channel 0 event");

   chain_event_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (st_reg.io1[7:6] == 2'h3 && ch0_reg_c_evt_i && !fld_wr[1])
      |=> capture_evt_o[1])
      else $error("ch1 register B capture gave no event");

   // channel 2 pin captures
   ch2_both_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (st_reg.io2[3:1] == 3'h7 && (pin_rise[2] || pin_fall[2]) && !fld_wr[2] && !gr_wr[2])
      |=> (gr[2] == $past(ch2_cnt_i)))
      else $error("ch2 register A missed an edge");

   ch2b_both_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (st_reg.io2[7:5] == 3'h7 && (pin_rise[3] || pin_fall[3]) && !fld_wr[3] && !gr_wr[3])
      |=> (gr[3] == $past(ch2_cnt_i)))
      else $error("ch2 register B missed an edge");

   ch2a_rise_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (st_reg.io2[3:0] == 4'hC && pin_rise[2] && !fld_wr[2] && !gr_wr[2])
      |=> (gr[2] == $past(ch2_cnt_i)))
      else $error("ch2 register A missed a rising edge");

   ch2b_rise_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (st_reg.io2[7:4] == 4'hC && pin_rise[3] && !fld_wr[3] && !gr_wr[3])
      |=> (gr[3] == $past(ch2_cnt_i)))
      else $error("ch2 register B missed a rising edge");

   ch2a_fall_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (st_reg.io2[3:0] == 4'hD && pin_fall[2] && !fld_wr[2] && !gr_wr[2])
      |=> (gr[2] == $past(ch2_cnt_i)))
      else $error("ch2 register A missed a falling edge");

   ch2b_fall_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (st_reg.io2[7:4] == 4'hD && pin_fall[3] && !fld_wr[3] && !gr_wr[3])
      |=> (gr[3] == $past(ch2_cnt_i)))
      else $error("ch2 register B missed a falling edge");

   // pin drive and release
   ch1a_drive_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (!st_reg.io1[3] && st_reg.io1[1:0] != 2'h0 && !fld_wr[0])
      |=> !ch1_pin_a_oe_n_o)
      else $error("ch1 pin A not driven in compare mode");

   ch1b_drive_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (!st_reg.io1[7] && st_reg.io1[5:4] != 2'h0 && !fld_wr[1])
      |=> !ch1_pin_b_oe_n_o)
      else $error("ch1 pin B not driven in compare mode");

   ch1a_release_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (st_reg.io1[3] && !fld_wr[0])
      |=> ch1_pin_a_oe_n_o)
      else $error("ch1 pin A driven in capture mode");

   ch1b_release_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (st_reg.io1[7] && !fld_wr[1])
      |=> ch1_pin_b_oe_n_o)
      else $error("ch1 pin B driven in capture mode");

   ch2a_release_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (st_reg.io2[3] && !fld_wr[2])
      |=> ch2_pin_a_oe_n_o)
      else $error("ch2 pin A driven in capture mode");

   ch2b_release_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (st_reg.io2[7] && !fld_wr[3])
      |=> ch2_pin_b_oe_n_o)
      else $error("ch2 pin B driven in capture mode");

   // compare outputs
   compare_event_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (!st_reg.io1[3] && gr[0] == ch1_cnt_i && !fld_wr[0])
      |=> capture_evt_o[0])
      else $error("ch1 register A match gave no event");

   ch2a_low_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (!st_reg.io2[3] && st_reg.io2[1:0] == 2'h1 && gr[2] == ch2_cnt_i && !fld_wr[2])
      |=> !ch2_pin_a_o)
      else $error("ch2 pin A not driven low on match");

   ch2b_high_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (!st_reg.io2[7] && st_reg.io2[5:4] == 2'h2 && gr[3] == ch2_cnt_i && !fld_wr[3])
      |=> ch2_pin_b_o)
      else $error("ch2 pin B not driven high on match");

   ch1b_toggle_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (!st_reg.io1[7] && st_reg.io1[5:4] == 2'h3 && gr[1] == ch1_cnt_i && !fld_wr[1])
      |=> (ch1_pin_b_o != $past(ch1_pin_b_o)))
      else $error("ch1 pin B not toggled on match");

   hold_level_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (!st_reg.io1[3] && st_reg.io1[1:0] == 2'h0 && !fld_wr[0])
      |=> $stable(ch1_pin_a_o))
      else $error("ch1 pin A level moved while output disabled");

   ch2_init_a: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (fld_wr[2] && !wdata_i[3])
      |=> (ch2_pin_a_o == $past(wdata_i[2])))
      else $error("ch2 pin A initial level not taken");
endmodule
`default_nettype wire

// ===== tmio_pin_model.sv
// Purpose: far side of the four timer pins of channels 1 and 2
// Assumes: each pin has a pull-up on the board
// Notes: the block wins while it drives; otherwise the outside driver or the pull-up sets the level
`timescale 1ns/100ps
`default_nettype none
module tmio_pin_model (
   input wire logic [3:0] drv_lvl_i,
   input wire logic [3:0] drv_en_i,
   input wire logic [3:0] dev_lvl_i,
   input wire logic [3:0] dev_oe_n_i,
   output logic [3:0] pin_o
);
   // a released pin floats to the pull-up level, never to its last value
   assign pin_o = (~dev_oe_n_i & dev_lvl_i) | (dev_oe_n_i & drv_en_i & drv_lvl_i) | (dev_oe_n_i & ~drv_en_i);
endmodule
`default_nettype wire

// ===== tb_top.sv
// Purpose: self-checking bench for the channel 1/2 pin function block
// Assumes: pin order 0 ch1 A, 1 ch1 B, 2 ch2 A, 3 ch2 B
// Notes: reset and map checks first, then capture rows, then reset-free hand tests for chaining and compare, then a mid-run reset
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   typedef struct packed {
      logic [3:0] code;
      logic [1:0] pin;
      logic start;
      logic hit;
   } tmio_row_type;
   tmio_row_type rows [12] = '{'{4'h8, 2'd0, 1'b0, 1'b1}, '{4'h8, 2'd0, 1'b1, 1'b0}, '{4'h9, 2'd0, 1'b1, 1'b1},
      '{4'h9, 2'd1, 1'b0, 1'b0}, '{4'hA, 2'd1, 1'b0, 1'b1}, '{4'hB, 2'd1, 1'b1, 1'b1},
      '{4'hC, 2'd2, 1'b0, 1'b1}, '{4'hD, 2'd2, 1'b0, 1'b0}, '{4'hE, 2'd2, 1'b1, 1'b1},
      '{4'hC, 2'd3, 1'b1, 1'b0}, '{4'hD, 2'd3, 1'b1, 1'b1}, '{4'hF, 2'd3, 1'b0, 1'b1}};
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [2:0] addr_i = 3'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [15:0] cnt1 = 16'h0000;
   logic [15:0] cnt2 = 16'h0000;
   logic evt_a = 1'b0;
   logic evt_c = 1'b0;
   logic [3:0] ext_lvl = 4'hF;
   logic [3:0] ext_en = 4'hF;
   logic [15:0] rdata_o;
   logic [15:0] rd_val;
   logic [3:0] dev_lvl;
   logic [3:0] dev_oe_n;
   logic [3:0] pin_lvl;
   logic [3:0] cap_evt;
   int errors = 0;
   int checks = 0;

   tmio_top DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .ch1_cnt_i(cnt1), .ch2_cnt_i(cnt2), .ch0_reg_a_evt_i(evt_a),
      .ch0_reg_c_evt_i(evt_c), .ch1_pin_a_i(pin_lvl[0]), .ch1_pin_b_i(pin_lvl[1]), .ch2_pin_a_i(pin_lvl[2]),
      .ch2_pin_b_i(pin_lvl[3]), .ch1_pin_a_o(dev_lvl[0]), .ch1_pin_b_o(dev_lvl[1]), .ch2_pin_a_o(dev_lvl[2]),
      .ch2_pin_b_o(dev_lvl[3]), .ch1_pin_a_oe_n_o(dev_oe_n[0]), .ch1_pin_b_oe_n_o(dev_oe_n[1]),
      .ch2_pin_a_oe_n_o(dev_oe_n[2]), .ch2_pin_b_oe_n_o(dev_oe_n[3]), .capture_evt_o(cap_evt));
   tmio_pin_model far_end (.drv_lvl_i(ext_lvl), .drv_en_i(ext_en), .dev_lvl_i(dev_lvl), .dev_oe_n_i(dev_oe_n),
      .pin_o(pin_lvl));

   initial begin
      forever #12.5 mclk_i = ~mclk_i;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask

   task automatic cap(input tmio_row_type r);
      logic [2:0] gr;
      gr = tmio_pkg::TMIO_OFS_CH1_GRA + {1'b0, r.pin};
      wr(r.pin[1] ? tmio_pkg::TMIO_OFS_CH2_IO : tmio_pkg::TMIO_OFS_CH1_IO, r.pin[0] ? {8'h00, r.code, 4'h0} : {12'h000, r.code});
      ext_lvl[r.pin] <= r.start;
      // clearing after the settle wipes any capture caused by the code change itself
      tick(6);
      wr(gr, 16'h0000);
      ext_lvl[r.pin] <= !r.start;
      tick(6);
      rd(gr, rd_val);
      chk("captured value", r.hit ? (r.pin[1] ? cnt2 : cnt1) : 16'h0000, rd_val);
   endtask

   task automatic hit;
      @(posedge mclk_i);
      cnt1 <= 16'h0010;
      @(posedge mclk_i);
      cnt1 <= 16'h0000;
      #1;
      chk("match event", 16'h0001, {15'h0000, cap_evt[0]});
      tick(2);
      #1;
   endtask

   task automatic oc(input logic [2:0] code);
      logic lvl;
      lvl = code[2];
      wr(tmio_pkg::TMIO_OFS_CH1_IO, {13'h0000, code});
      tick(1);
      #1;
      chk("pin enable", {15'h0000, code[1:0] == 2'h0}, {15'h0000, dev_oe_n[0]});
      if (code[1:0] != 2'h0) begin
         chk("initial level", {15'h0000, lvl}, {15'h0000, dev_lvl[0]});
         repeat (2) begin
            hit();
            lvl = (code[1:0] == 2'h1) ? 1'b0 : (code[1:0] == 2'h2) ? 1'b1 : !lvl;
            chk("match level", {15'h0000, lvl}, {15'h0000, dev_lvl[0]});
         end
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      // whole run is under a thousand cycles; this allows eight times that
      #200000;
      errors++;
      wrap_up();
   end

   initial begin
      tick(3);
      rst_n_i <= 1'b1;
      rd(tmio_pkg::TMIO_OFS_CH1_IO, rd_val);
      chk("ch1 io reset", 16'h0000, rd_val);
      rd(tmio_pkg::TMIO_OFS_CH2_IO, rd_val);
      chk("ch2 io reset", 16'h0000, rd_val);
      chk("oe_n reset", 16'h000F, {12'h000, dev_oe_n});
      wr(3'h6, 16'hFFFF);
      rd(3'h6, rd_val);
      chk("unmapped", 16'h0000, rd_val);
      $display("test reset and map done");
      cnt1 <= 16'h1234;
      cnt2 <= 16'h5678;
      foreach (rows[i]) begin
         cap(rows[i]);
      end
      $display("test pin captures done");
      wr(tmio_pkg::TMIO_OFS_CH1_IO, 16'h00CC);
      wr(tmio_pkg::TMIO_OFS_CH1_GRA, 16'h0000);
      wr(tmio_pkg::TMIO_OFS_CH1_GRB, 16'h0000);
      evt_c <= 1'b1;
      @(posedge mclk_i);
      evt_c <= 1'b0;
      tick(2);
      rd(tmio_pkg::TMIO_OFS_CH1_GRB, rd_val);
      chk("chain reg b", 16'h1234, rd_val);
      rd(tmio_pkg::TMIO_OFS_CH1_GRA, rd_val);
      chk("chain reg a idle", 16'h0000, rd_val);
      evt_a <= 1'b1;
      @(posedge mclk_i);
      evt_a <= 1'b0;
      tick(2);
      rd(tmio_pkg::TMIO_OFS_CH1_GRA, rd_val);
      chk("chain reg a", 16'h1234, rd_val);
      $display("test chaining done");
      ext_en <= 4'h0;
      cnt1 <= 16'h0000;
      wr(tmio_pkg::TMIO_OFS_CH1_GRA, 16'h0010);
      for (int c = 0; c < 8; c++) begin
         oc(c[2:0]);
      end
      $display("test compare outputs done");
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      tick(2);
      rst_n_i <= 1'b1;
      rd(tmio_pkg::TMIO_OFS_CH1_IO, rd_val);
      chk("ch1 io mid reset", 16'h0000, rd_val);
      chk("oe_n mid reset", 16'h000F, {12'h000, dev_oe_n});
      rd(tmio_pkg::TMIO_OFS_CH1_GRA, rd_val);
      chk("gr mid reset", tmio_pkg::TMIO_GR_RESET, rd_val);
      $display("test mid-run reset done");
      wrap_up();
   end
endmodule
`default_nettype wire
